//--- shared/bslc_pkg.sv
// Constants and types shared by the reference slew and limit controller
`default_nettype none
package bslc_pkg;
  // Clock
  localparam int CLK_NS = 40;

  // Register offsets
  localparam logic [7:0] REG_TARGET = 8'h01;
  localparam logic [7:0] REG_REFCTL = 8'h02;
  localparam logic [7:0] REG_FREQ   = 8'h03;
  localparam logic [7:0] REG_LIMIT  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_REFNOW = 8'h06;

  // Reset values, target minimum and reserved frequency codes
  localparam logic [7:0] TARGET_RESET = 8'h32;
  localparam logic [7:0] TARGET_MIN   = 8'h1e;
  localparam logic       HALF_RESET   = 1'h0;
  localparam logic       FINE_RESET   = 1'h0;
  localparam logic [1:0] SLEW_RESET   = 2'h0;
  localparam logic [2:0] GM_RESET     = 3'h5;
  localparam logic [2:0] FREQ_RESET   = 3'h0;
  localparam logic [2:0] FREQ_RSV_A   = 3'h6;
  localparam logic [2:0] FREQ_RSV_B   = 3'h7;
  localparam logic [1:0] LIMIT_RESET  = 2'h0;

  // Control register fields
  localparam int REFCTL_HALF = 0;
  localparam int REFCTL_FINE = 1;
  localparam int REFCTL_SLEW = 2;
  localparam int REFCTL_GM   = 4;

  // Status register fields
  localparam int STAT_FAULT   = 0;
  localparam int STAT_ENABLED = 1;
  localparam int STAT_SETTLED = 2;
  localparam int STAT_NONSYNC = 3;
  localparam int STAT_LIMIT   = 4;

  // Synchronised pin order
  localparam int PIN_ENABLE  = 0;
  localparam int PIN_PREBIAS = 1;
  localparam int PIN_BOOSTUV = 2;
  localparam int PIN_PWMHIGH = 3;
  localparam int PIN_CYCLE   = 4;
  localparam int PIN_TRIP    = 5;
  localparam int PIN_COUNT   = 6;

  // Slew timing: one 5 mV step at the slowest rate
  localparam int FINE_STEP_UV  = 5000;
  localparam int SLOW_UV_PER_US = 600;
  localparam int FINE_STEP_NS  = FINE_STEP_UV * 1000 / SLOW_UV_PER_US;
  localparam int TICK_W        = 12;
  localparam logic [TICK_W-1:0] FINE_TICKS_SLOW = TICK_W'(FINE_STEP_NS / CLK_NS);
  localparam logic [8:0] STEP_FINE   = 9'h001;
  localparam logic [8:0] STEP_COARSE = 9'h002;

  // Current limit and boost refresh
  localparam logic [2:0] OCP_LIMIT_CYCLES = 3'h4;
  localparam int REFRESH_NS = 200;
  localparam logic [2:0] REFRESH_CYCLES = 3'((REFRESH_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {ST_OFF, ST_START, ST_RUN} bslc_state_t;
endpackage : bslc_pkg
`default_nettype wire

//--- design/bslc_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module bslc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;

  // Output moves only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      pinOut     <= '0;
    end else if (clkEn) begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (int i = 0; i < W; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          pinOut[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule : bslc_sync
`default_nettype wire

//--- design/bslc_tick.sv
// Slew clock: one-cycle tick every interval cycles
`default_nettype none
module bslc_tick #(
  parameter int W = 12
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  input  wire logic         run,
  input  wire logic [W-1:0] interval,
  output logic              tick
);
  logic [W-1:0] count_reg;
  logic         wrap;

  assign wrap = (count_reg + W'(1)) >= interval;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else if (clkEn) begin
      if (!run || wrap) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + W'(1);
      end
      tick <= run && wrap;
    end
  end
endmodule : bslc_tick
`default_nettype wire

//--- design/bslc_core.sv
// Reference slew, gm, frequency lock and peak current limit control core
`default_nettype none
module bslc_core (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       enablePin,
  input  wire logic       prebiasPin,
  input  wire logic       boostUvPin,
  input  wire logic       pwmHighPin,
  input  wire logic       cycleStartPin,
  input  wire logic       sensePairTwoTripPin,
  output logic      [8:0] refCode,
  output logic      [2:0] gmSelect,
  output logic      [1:0] peakLimitSelect,
  output logic      [2:0] switchingFrequencyField,
  output logic            highSideSwitch,
  output logic            lowSideSwitch,
  output logic            ocpFault,
  output logic            nonSyncMode
);
  // Register state
  logic [7:0]  target_reg;
  logic        half_reg;
  logic        fine_reg;
  logic [1:0]  slew_reg;
  logic [2:0]  gm_reg;
  logic [2:0]  freq_reg;
  logic [1:0]  limit_reg;

  // Control state
  bslc_pkg::bslc_state_t state_reg;
  bslc_pkg::bslc_state_t state_next;
  logic [8:0]  ref_reg;
  logic [8:0]  ref_next;
  logic        enPrev_reg;
  logic        cyclePrev_reg;
  logic        trip_reg;
  logic        trip_next;
  logic [2:0]  ocpCount_reg;
  logic [2:0]  ocpCount_next;
  logic        fault_reg;
  logic        fault_next;
  logic        nonSync_reg;
  logic        nonSync_next;
  logic [2:0]  refresh_reg;
  logic [2:0]  refresh_next;

  // Synchronised pins
  logic [bslc_pkg::PIN_COUNT-1:0] pinRaw;
  logic [bslc_pkg::PIN_COUNT-1:0] pinSync;
  logic        enNow;
  logic        prebiasNow;
  logic        boostUvNow;
  logic        pwmHighNow;
  logic        cycleNow;
  logic        tripNow;

  // Decode wires
  logic        wrTarget;
  logic        wrRefCtl;
  logic        wrFreq;
  logic        wrLimit;
  logic        freqReserved;
  logic        enRise;
  logic        enToggle;
  logic        cycleEdge;
  logic        faultSet;
  logic [8:0]  target9;
  logic        rampUp;
  logic        rampDown;
  logic        atTarget;
  logic [8:0]  gap;
  logic [8:0]  stepWant;
  logic [8:0]  stepSize;
  logic [bslc_pkg::TICK_W-1:0] baseTicks;
  logic [bslc_pkg::TICK_W-1:0] tickInterval;
  logic        tick;
  logic        switching;
  logic        refreshStart;
  logic        refreshActive;
  logic        highNext;
  logic        lowNext;
  logic [7:0]  statusByte;
  logic [7:0]  rdMux;

  assign pinRaw = {sensePairTwoTripPin, cycleStartPin, pwmHighPin,
                   boostUvPin, prebiasPin, enablePin};

  bslc_sync #(
    .W (bslc_pkg::PIN_COUNT)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .pinIn   (pinRaw),
    .pinOut  (pinSync)
  );

  assign enNow      = pinSync[bslc_pkg::PIN_ENABLE];
  assign prebiasNow = pinSync[bslc_pkg::PIN_PREBIAS];
  assign boostUvNow = pinSync[bslc_pkg::PIN_BOOSTUV];
  assign pwmHighNow = pinSync[bslc_pkg::PIN_PWMHIGH];
  assign cycleNow   = pinSync[bslc_pkg::PIN_CYCLE];
  assign tripNow    = pinSync[bslc_pkg::PIN_TRIP];

  // Register write decode
  assign wrTarget = regWrEn && regAddr == bslc_pkg::REG_TARGET
                    && regWrData >= bslc_pkg::TARGET_MIN;
  assign wrRefCtl = regWrEn && regAddr == bslc_pkg::REG_REFCTL;
  assign freqReserved = regWrData[2:0] == bslc_pkg::FREQ_RSV_A
                        || regWrData[2:0] == bslc_pkg::FREQ_RSV_B;
  // Ignoring writes while enabled is the lock itself
  assign wrFreq  = regWrEn && regAddr == bslc_pkg::REG_FREQ
                   && !enNow && !freqReserved;
  assign wrLimit = regWrEn && regAddr == bslc_pkg::REG_LIMIT;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      target_reg <= bslc_pkg::TARGET_RESET;
      half_reg   <= bslc_pkg::HALF_RESET;
      fine_reg   <= bslc_pkg::FINE_RESET;
      slew_reg   <= bslc_pkg::SLEW_RESET;
      gm_reg     <= bslc_pkg::GM_RESET;
      freq_reg   <= bslc_pkg::FREQ_RESET;
      limit_reg  <= bslc_pkg::LIMIT_RESET;
    end else if (clkEn) begin
      if (wrTarget) begin
        target_reg <= regWrData;
      end
      if (wrRefCtl) begin
        half_reg <= regWrData[bslc_pkg::REFCTL_HALF];
        fine_reg <= regWrData[bslc_pkg::REFCTL_FINE];
        slew_reg <= regWrData[bslc_pkg::REFCTL_SLEW +: 2];
        gm_reg   <= regWrData[bslc_pkg::REFCTL_GM +: 3];
      end
      if (wrFreq) begin
        freq_reg <= regWrData[2:0];
      end
      if (wrLimit) begin
        limit_reg <= regWrData[1:0];
      end
    end
  end

  // Read path
  assign statusByte = {3'h0, trip_reg, nonSync_reg, state_reg == bslc_pkg::ST_RUN,
                       enNow, fault_reg};
  assign rdMux = (regAddr == bslc_pkg::REG_TARGET) ? target_reg :
                 (regAddr == bslc_pkg::REG_REFCTL) ?
                   {1'b0, gm_reg, slew_reg, fine_reg, half_reg} :
                 (regAddr == bslc_pkg::REG_FREQ)   ? {5'h00, freq_reg} :
                 (regAddr == bslc_pkg::REG_LIMIT)  ? {6'h00, limit_reg} :
                 (regAddr == bslc_pkg::REG_STATUS) ? statusByte :
                 (regAddr == bslc_pkg::REG_REFNOW) ? ref_reg[8:1] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (clkEn && regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // Edges
  assign enRise    = enNow && !enPrev_reg;
  assign enToggle  = enNow != enPrev_reg;
  assign cycleEdge = cycleNow && !cyclePrev_reg;

  // Slew tick: each slew step halves the interval; coarse steps take twice as long
  assign baseTicks    = fine_reg ? bslc_pkg::FINE_TICKS_SLOW
                                 : bslc_pkg::FINE_TICKS_SLOW << 1;
  assign tickInterval = baseTicks >> slew_reg;

  bslc_tick #(
    .W (bslc_pkg::TICK_W)
  ) u_tick (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .run      (state_reg != bslc_pkg::ST_OFF),
    .interval (tickInterval),
    .tick     (tick)
  );

  // Ramp arithmetic
  assign target9  = {target_reg, half_reg};
  assign rampUp   = ref_reg < target9;
  assign rampDown = ref_reg > target9;
  assign atTarget = ref_reg == target9;
  assign gap      = rampUp ? target9 - ref_reg : ref_reg - target9;
  assign stepWant = fine_reg ? bslc_pkg::STEP_FINE : bslc_pkg::STEP_COARSE;
  // Last step shrinks so an odd target is met exactly
  assign stepSize = (gap < stepWant) ? gap : stepWant;

  always_comb begin
    state_next = state_reg;
    ref_next   = ref_reg;
    unique case (state_reg)
      bslc_pkg::ST_OFF: begin
        ref_next = 9'h000;
        if (enRise) begin
          state_next = bslc_pkg::ST_START;
        end
      end
      bslc_pkg::ST_START, bslc_pkg::ST_RUN: begin
        if (tick && rampUp && !trip_reg) begin
          ref_next = ref_reg + stepSize;
        end else if (tick && rampDown) begin
          ref_next = ref_reg - stepSize;
        end
        if (atTarget) begin
          state_next = bslc_pkg::ST_RUN;
        end
      end
    endcase
    if (!enNow) begin
      state_next = bslc_pkg::ST_OFF;
      ref_next   = 9'h000;
    end
  end

  // Peak limit: trip re-arms each cycle; a trip on the edge counts for the new cycle
  always_comb begin
    trip_next     = trip_reg | tripNow;
    ocpCount_next = ocpCount_reg;
    if (cycleEdge) begin
      trip_next = tripNow;
      if (trip_reg) begin
        if (ocpCount_reg != bslc_pkg::OCP_LIMIT_CYCLES) begin
          ocpCount_next = ocpCount_reg + 3'h1;
        end
      end else begin
        ocpCount_next = 3'h0;
      end
    end
    if (!enNow) begin
      trip_next     = 1'b0;
      ocpCount_next = 3'h0;
    end
  end

  // Fifth limited cycle in a row latches the fault
  assign faultSet = enNow && cycleEdge && trip_reg
                    && ocpCount_reg == bslc_pkg::OCP_LIMIT_CYCLES;

  always_comb begin
    fault_next = fault_reg;
    if (faultSet) begin
      fault_next = 1'b1;
    end else if (enToggle) begin
      fault_next = 1'b0;
    end
  end

  // Prebias is sampled once, at the enable edge
  always_comb begin
    nonSync_next = nonSync_reg;
    if (enRise) begin
      nonSync_next = prebiasNow;
    end else if (!enNow || state_reg == bslc_pkg::ST_RUN) begin
      nonSync_next = 1'b0;
    end
  end

  // Boost refresh pulse while the high side is held on
  // Next fault value, so the latching edge already stops both gates
  assign switching     = enNow && !fault_next;
  assign refreshActive = refresh_reg != 3'h0;
  assign refreshStart  = switching && pwmHighNow && boostUvNow && !refreshActive;

  always_comb begin
    refresh_next = refresh_reg;
    if (refreshStart) begin
      refresh_next = bslc_pkg::REFRESH_CYCLES;
    end else if (refreshActive) begin
      refresh_next = refresh_reg - 3'h1;
    end
  end

  // Gate drive; high and low are never on together
  assign highNext = switching && pwmHighNow && !trip_next
                    && !refreshActive && !refreshStart;
  assign lowNext  = switching && !highNext
                    && (refreshActive || refreshStart
                        || (!pwmHighNow && !nonSync_next));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg     <= bslc_pkg::ST_OFF;
      ref_reg       <= 9'h000;
      enPrev_reg    <= 1'b0;
      cyclePrev_reg <= 1'b0;
      trip_reg      <= 1'b0;
      ocpCount_reg  <= 3'h0;
      fault_reg     <= 1'b0;
      nonSync_reg   <= 1'b0;
      refresh_reg   <= 3'h0;
    end else if (clkEn) begin
      state_reg     <= state_next;
      ref_reg       <= ref_next;
      enPrev_reg    <= enNow;
      cyclePrev_reg <= cycleNow;
      trip_reg      <= trip_next;
      ocpCount_reg  <= ocpCount_next;
      fault_reg     <= fault_next;
      nonSync_reg   <= nonSync_next;
      refresh_reg   <= refresh_next;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      refCode                 <= 9'h000;
      gmSelect                <= bslc_pkg::GM_RESET;
      peakLimitSelect         <= bslc_pkg::LIMIT_RESET;
      switchingFrequencyField <= bslc_pkg::FREQ_RESET;
      highSideSwitch          <= 1'b0;
      lowSideSwitch           <= 1'b0;
      ocpFault                <= 1'b0;
      nonSyncMode             <= 1'b0;
    end else if (clkEn) begin
      refCode                 <= ref_next;
      gmSelect                <= gm_reg;
      peakLimitSelect         <= limit_reg;
      switchingFrequencyField <= freq_reg;
      highSideSwitch          <= highNext;
      lowSideSwitch           <= lowNext;
      ocpFault                <= fault_next;
      nonSyncMode             <= nonSync_next;
    end
  end
endmodule : bslc_core
`default_nettype wire

//--- tb/bslc_core_properties.sv
// Port-level checks for the slew and limit core
`default_nettype none
module bslc_core_properties (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       clkEn,
  input wire logic       regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       enablePin,
  input wire logic       boostUvPin,
  input wire logic       pwmHighPin,
  input wire logic       sensePairTwoTripPin,
  input wire logic [8:0] refCode,
  input wire logic [2:0] gmSelect,
  input wire logic [2:0] switchingFrequencyField,
  input wire logic       highSideSwitch,
  input wire logic       lowSideSwitch,
  input wire logic       ocpFault
);
  logic [2:0] enStable;
  logic       enPrev;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // Pin must sit still well past the synchroniser lag
  always_ff @(posedge ref_clk) begin
    enPrev <= enablePin;
    enStable <= (!rstn || enablePin != enPrev) ? 3'h0 : (enStable == 3'h7) ? 3'h7 : enStable + 3'h1;
  end

  chk_reset_values: assert property (
    disable iff (1'b0) (!rstn && clkEn) |=> gmSelect == 3'h5 && refCode == 9'h000 && !ocpFault)
    else $error("reset values wrong");
  chk_step_size: assert property (
    refCode > $past(refCode) |-> refCode - $past(refCode) <= 9'h002)
    else $error("reference step too large");
  chk_trip_cuts: assert property (
    sensePairTwoTripPin [*6] |=> !highSideSwitch)
    else $error("high side on during trip");
  chk_trip_holds: assert property (
    sensePairTwoTripPin [*6] |=> refCode <= $past(refCode))
    else $error("reference rose during trip");
  chk_fault_quiet: assert property (
    ocpFault |-> !highSideSwitch && !lowSideSwitch)
    else $error("switching during fault");
  chk_fault_latched: assert property (
    ocpFault && enStable >= 3'h6 |=> ocpFault)
    else $error("fault cleared without enable change");
  chk_boost_refresh: assert property (
    (enablePin && pwmHighPin && boostUvPin && !ocpFault) [*8] |-> ##[0:6] lowSideSwitch)
    else $error("no boost refresh");
  chk_freq_lock: assert property (
    enablePin [*8] |=> $stable(switchingFrequencyField))
    else $error("frequency moved while enabled");
  chk_freq_reserved: assert property (
    regWrEn && regAddr == bslc_pkg::REG_FREQ && regWrData[2:1] == 2'h3 |=> $stable(switchingFrequencyField))
    else $error("reserved frequency taken");
  chk_gm_by_write: assert property (
    !$stable(gmSelect) |-> $past(regWrEn, 2) && $past(regAddr, 2) == bslc_pkg::REG_REFCTL
      && ($past(regWrData, 2) & 8'h70) == {1'b0, gmSelect, 4'h0})
    else $error("gm changed without write");
  chk_off_zero: assert property (
    !enablePin [*6] |=> refCode == 9'h000)
    else $error("reference not zero when off");
endmodule : bslc_core_properties

bind bslc_core bslc_core_properties bslc_core_properties_inst (.ref_clk, .rstn, .clkEn, .regWrEn, .regAddr,
  .regWrData, .enablePin, .boostUvPin, .pwmHighPin, .sensePairTwoTripPin, .refCode, .gmSelect,
  .switchingFrequencyField, .highSideSwitch, .lowSideSwitch, .ocpFault);
`default_nettype wire

//--- tb/bslc_host.sv
// Host model: register writes, reads and the enable pin
`default_nettype none
module bslc_host #(
  parameter int RESTART_WAIT = 82500
) (
  input  wire logic       ref_clk,
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  output var  logic       enablePin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    enablePin = 1'b0;
  end

  // Extra cycle lets registered outputs settle before callers look
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask : rd

  task automatic set_enable(input logic v);
    if (v) begin
      repeat (RESTART_WAIT) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    enablePin = v;
  endtask : set_enable

  task automatic set_freq(input logic [7:0] d);
    set_enable(1'b0);
    repeat (6) @(negedge ref_clk);
    wr(bslc_pkg::REG_FREQ, d);
  endtask : set_freq
endmodule : bslc_host
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the slew and limit core
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nFail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       clkEn = 1'b1;
  logic       regWrEn, regRdEn, enablePin;
  logic [7:0] regAddr, regWrData, regRdData, rv;
  logic       prebiasPin = 1'b0;
  logic       boostUvPin = 1'b0;
  logic       pwmHighPin = 1'b0;
  logic       cycleStartPin = 1'b0;
  logic       sensePairTwoTripPin = 1'b0;
  logic [8:0] refCode;
  logic [2:0] gmSelect, switchingFrequencyField;
  logic [1:0] peakLimitSelect;
  logic       highSideSwitch, lowSideSwitch, ocpFault, nonSyncMode, seen;
  int         nFail = 0;
  int         checkCount = 0;
  int         n;

  always #(bslc_pkg::CLK_NS / 2) ref_clk = ~ref_clk;

  bslc_core bslc_core_inst (.ref_clk, .rstn, .clkEn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .enablePin, .prebiasPin, .boostUvPin, .pwmHighPin, .cycleStartPin, .sensePairTwoTripPin, .refCode,
    .gmSelect, .peakLimitSelect, .switchingFrequencyField, .highSideSwitch, .lowSideSwitch, .ocpFault,
    .nonSyncMode);
  // Restart wait shortened from 3.3 ms to keep the run brief
  bslc_host #(.RESTART_WAIT(250)) bslc_host_inst (.ref_clk, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData, .enablePin);

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wait_change();
    logic [8:0] v;
    v = refCode;
    n = 0;
    while (refCode === v && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_change

  task automatic wait_ref(input logic [8:0] v);
    n = 0;
    while (refCode !== v && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(refCode, v)
  endtask : wait_ref

  // First change may be a partial interval, so time the second
  task automatic step(input logic [8:0] d, input int gap);
    logic [8:0] v;
    wait_change();
    v = refCode;
    wait_change();
    `CHK(9'(refCode - v), d)
    `CHK(n, gap)
  endtask : step

  task automatic run_cycle(input logic trip, input logic expHigh);
    cycleStartPin = 1'b1;
    sensePairTwoTripPin = trip;
    repeat (6) @(negedge ref_clk);
    cycleStartPin = 1'b0;
    sensePairTwoTripPin = 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK(highSideSwitch, expHigh)
    @(negedge ref_clk);
  endtask : run_cycle

  task automatic t_reset();
    bslc_host_inst.rd(bslc_pkg::REG_TARGET, rv);
    `CHK(rv, 8'h32)
    bslc_host_inst.rd(bslc_pkg::REG_REFCTL, rv);
    `CHK(rv, 8'h50)
    `CHK(gmSelect, 3'h5)
    `CHK(switchingFrequencyField, 3'h0)
    bslc_host_inst.rd(8'h07, rv);
    `CHK(rv, 8'h00)
    bslc_host_inst.wr(bslc_pkg::REG_TARGET, 8'h1d);
    bslc_host_inst.rd(bslc_pkg::REG_TARGET, rv);
    `CHK(rv, 8'h32)
    bslc_host_inst.wr(bslc_pkg::REG_TARGET, 8'hff);
    bslc_host_inst.rd(bslc_pkg::REG_TARGET, rv);
    `CHK(rv, 8'hff)
    bslc_host_inst.wr(bslc_pkg::REG_TARGET, 8'h1e);
    bslc_host_inst.rd(bslc_pkg::REG_TARGET, rv);
    `CHK(rv, 8'h1e)
  endtask : t_reset

  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      bslc_host_inst.wr(bslc_pkg::REG_REFCTL, {1'b0, 3'(i), 4'hc});
      `CHK(gmSelect, 3'(i))
    end
    for (int i = 0; i < 4; i++) begin
      bslc_host_inst.wr(bslc_pkg::REG_LIMIT, {6'h00, 2'(i)});
      `CHK(peakLimitSelect, 2'(i))
    end
    for (int i = 0; i < 8; i++) begin
      bslc_host_inst.set_freq({5'h00, 3'(i)});
      `CHK(switchingFrequencyField, (i < 6) ? 3'(i) : 3'h5)
    end
  endtask : t_codes

  task automatic t_ramp();
    bslc_host_inst.set_enable(1'b1);
    wait_ref(9'h03c);
    bslc_host_inst.wr(bslc_pkg::REG_TARGET, 8'h28);
    step(9'h002, 52);
    bslc_host_inst.wr(bslc_pkg::REG_REFCTL, 8'h54);
    step(9'h002, 208);
    bslc_host_inst.wr(bslc_pkg::REG_REFCTL, 8'h58);
    step(9'h002, 104);
    bslc_host_inst.wr(bslc_pkg::REG_REFCTL, 8'h50);
    step(9'h002, 416);
    bslc_host_inst.wr(bslc_pkg::REG_TARGET, 8'h1e);
    step(9'h1fe, 416);
    bslc_host_inst.wr(bslc_pkg::REG_REFCTL, 8'h5e);
    step(9'h1ff, 26);
    wait_ref(9'h03c);
    bslc_host_inst.wr(bslc_pkg::REG_REFCTL, 8'h5f);
    wait_ref(9'h03d);
    bslc_host_inst.rd(bslc_pkg::REG_REFNOW, rv);
    `CHK(rv, 8'h1e)
    bslc_host_inst.wr(bslc_pkg::REG_FREQ, 8'h01);
    `CHK(switchingFrequencyField, 3'h5)
  endtask : t_ramp

  task automatic t_boost_limit();
    pwmHighPin = 1'b1;
    boostUvPin = 1'b1;
    seen = 1'b0;
    repeat (20) @(negedge ref_clk) seen |= lowSideSwitch;
    `CHK(seen, 1'b1)
    boostUvPin = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK(lowSideSwitch, 1'b0)
    repeat (4) run_cycle(1'b1, 1'b0);
    repeat (2) run_cycle(1'b0, 1'b1);
    `CHK(ocpFault, 1'b0)
    repeat (4) run_cycle(1'b1, 1'b0);
    `CHK(ocpFault, 1'b0)
    run_cycle(1'b1, 1'b0);
    run_cycle(1'b0, 1'b0);
    `CHK(ocpFault, 1'b1)
    bslc_host_inst.set_enable(1'b0);
    repeat (8) @(negedge ref_clk);
    `CHK(ocpFault, 1'b0)
  endtask : t_boost_limit

  task automatic t_prebias();
    pwmHighPin = 1'b0;
    prebiasPin = 1'b1;
    bslc_host_inst.set_enable(1'b1);
    repeat (10) @(negedge ref_clk);
    `CHK(nonSyncMode, 1'b1)
    `CHK(lowSideSwitch, 1'b0)
  endtask : t_prebias

  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_codes();
    t_ramp();
    t_boost_limit();
    t_prebias();
    report_and_stop();
  end

  // Whole sequence needs about 5000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    nFail++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
